/* hw/ccb_top.sv */
/*
  Clock, baud selection and internal bus decode glue of the communications card.
  Oscillator and counter/timer zero-count outputs arrive as pins and are sampled
  by SYS_CLK, which must run well above twice the oscillator rate.
  Every output is registered; decode, wait, data and remote clock paths lag their cause by one SYS_CLK cycle
  beyond the two-stage input synchronisers, and the divided clocks by two or more.
*/
`timescale 1ns/1ps
module ccb_top
  import ccb_pkg::*;
#(
  parameter int unsigned N = BAUD_CH
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RSTN,
  input  wire logic              OSC_IN,
  input  wire logic [ADDR_W-1:0] INTERNAL_ADDR,
  input  wire logic              INTERNAL_MEM_REQUEST_N,
  input  wire logic              INTERNAL_RD_N,
  input  wire logic              INTERNAL_WR_N,
  input  wire logic              INTERNAL_IO_REQUEST_N,
  input  wire logic [SW_W-1:0]   DEFAULT_SWITCH_BANK,
  input  wire logic [N-1:0]      ZERO_COUNT_OUTPUT,
  input  wire logic [1:0]        TIMER23_SRC,
  input  wire logic [7:0]        MODEM_CONTROL,
  input  wire logic              REMOTE_RX_CLK,
  input  wire logic              REMOTE_TX_CLK,
  input  wire logic              SERIAL_WAIT_READY_A_N,
  input  wire logic              WAIT_ENABLE,
  input  wire logic              INT_REQ_N,
  input  wire logic              CHA_TXD,
  input  wire logic              REMOTE_RXD,
  output logic                   ROM_SELECT_N,
  output logic [NIB_W-1:0]       SWITCH_DATA_OUT,
  output logic                   SWITCH_DATA_OE,
  output logic                   SYSTEM_CLOCK,
  output logic                   ARBITER_CLOCK,
  output logic                   TIMER_EXT_CLK01,
  output logic [1:0]             TIMER_EXT_CLK23,
  output logic [N-1:0]           BAUD_CLOCK,
  output logic                   SERIAL_RX_CLOCK,
  output logic                   SERIAL_TX_CLOCK,
  output logic                   CPU_WAIT_N,
  output logic                   REMOTE_TXD,
  output logic                   CHA_RXD,
  output logic                   CHB_RXD
);
  if (N < 1 || N > 4) begin : g_bad_n
    $error("ccb_top: N must be 1 to 4");
  end

  // Two-stage synchronisers for every pin from outside SYS_CLK
  localparam int unsigned SW = ADDR_W + 4 + SW_W + N + 10 + 2;
  logic [SW-1:0] meta;
  logic [SW-1:0] sync;
  logic [SW-1:0] raw;

  assign raw = {INTERNAL_ADDR, INTERNAL_MEM_REQUEST_N, INTERNAL_RD_N, INTERNAL_WR_N,
                INTERNAL_IO_REQUEST_N, DEFAULT_SWITCH_BANK, ZERO_COUNT_OUTPUT,
                MODEM_CONTROL[MC_RX_BIT], MODEM_CONTROL[MC_TX_BIT], REMOTE_RX_CLK,
                REMOTE_TX_CLK, SERIAL_WAIT_READY_A_N, WAIT_ENABLE, INT_REQ_N, CHA_TXD,
                REMOTE_RXD, OSC_IN, TIMER23_SRC};

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end

  logic [ADDR_W-1:0] addr;
  logic              mreq_n;
  logic              rd_n;
  logic              wr_n;
  logic              ioreq_n;
  logic [SW_W-1:0]   sw;
  logic [N-1:0]      zc;
  logic              mc_rx;
  logic              mc_tx;
  logic              rrx_clk;
  logic              rtx_clk;
  logic              serial_wait_n;
  logic              wait_en;
  logic              irq_n;
  logic              txd_a;
  logic              rxd_remote;
  logic              osc;
  logic [1:0]        t23_src;

  assign {addr, mreq_n, rd_n, wr_n, ioreq_n, sw, zc, mc_rx, mc_tx, rrx_clk, rtx_clk,
          serial_wait_n, wait_en, irq_n, txd_a, rxd_remote, osc, t23_src} = sync;

  // Edge detection reads only the second stage and its delayed copy
  logic         osc_prev;
  logic [N-1:0] zc_prev;

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      osc_prev <= 1'b0;
      zc_prev  <= '0;
    end else begin
      osc_prev <= osc;
      zc_prev  <= zc;
    end
  end

  ccb_div_if #(.N(N)) dvif ();

  assign dvif.osc_tick = osc & ~osc_prev;
  assign dvif.zc_tick  = zc & ~zc_prev;

  ccb_div #(.N(N)) u_div (
    .sys_clk (SYS_CLK),
    .rst_n   (RSTN),
    .dv      (dvif.divider)
  );

  // ROM answers only memory reads in the lower half; never writes or io
  logic next_rom_sel_n;
  assign next_rom_sel_n = ~(~mreq_n & ~rd_n & wr_n & ioreq_n
                            & ~addr[ROM_ABIT]);

  // Switch nibble mux with its tri-state enable
  logic             next_sw_oe;
  logic [NIB_W-1:0] next_sw_nib;
  assign next_sw_oe  = ~addr[SW_EN_ABIT] & ~ioreq_n;
  assign next_sw_nib = addr[SW_SEL_ABIT] ? sw[SW_W-1:NIB_W]
                                         : sw[NIB_W-1:0];

  // Baud mux: set bits choose internal counter clocks, clear bits remote clocks
  logic next_rx_clk;
  logic next_tx_clk;
  assign next_rx_clk = (mc_rx == SEL_INTERNAL) ? dvif.baud_q[0] : rrx_clk;
  assign next_tx_clk = (mc_tx == SEL_INTERNAL) ? dvif.baud_q[N-1] : rtx_clk;

  // Software timers count system clock, half clock or a baud clock
  logic next_t23;
  assign next_t23 = (t23_src == TMR_SRC_SYS)  ? dvif.sys_clk_q  :
                    (t23_src == TMR_SRC_HALF) ? dvif.half_clk_q :
                                                dvif.baud_q[0];

  // Interrupt wins over the serial controller's wait
  logic next_wait_n;
  assign next_wait_n = ~(wait_en & ~serial_wait_n & irq_n);

  // Output registers grouped by function; each adds one cycle, on top of the divider stages for the divided clocks
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      ROM_SELECT_N    <= 1'b1;
      SWITCH_DATA_OUT <= '0;
      SWITCH_DATA_OE  <= 1'b0;
    end else begin
      ROM_SELECT_N    <= next_rom_sel_n;
      SWITCH_DATA_OUT <= next_sw_nib;
      SWITCH_DATA_OE  <= next_sw_oe;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      SYSTEM_CLOCK    <= 1'b0;
      ARBITER_CLOCK   <= 1'b0;
      TIMER_EXT_CLK01 <= 1'b0;
      TIMER_EXT_CLK23 <= '0;
      BAUD_CLOCK      <= '0;
    end else begin
      SYSTEM_CLOCK    <= dvif.sys_clk_q;
      ARBITER_CLOCK   <= dvif.sys_clk_q;
      TIMER_EXT_CLK01 <= dvif.half_clk_q;
      TIMER_EXT_CLK23 <= {2{next_t23}};
      BAUD_CLOCK      <= dvif.baud_q;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      SERIAL_RX_CLOCK <= 1'b0;
      SERIAL_TX_CLOCK <= 1'b0;
      CPU_WAIT_N      <= 1'b1;
    end else begin
      SERIAL_RX_CLOCK <= next_rx_clk;
      SERIAL_TX_CLOCK <= next_tx_clk;
      CPU_WAIT_N      <= next_wait_n;
    end
  end

  // Data lines idle at mark in reset, then show space for two cycles after release while the cleared synchronisers flush
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      REMOTE_TXD      <= 1'b1;
      CHA_RXD         <= 1'b1;
      CHB_RXD         <= 1'b1;
    end else begin
      REMOTE_TXD      <= txd_a;
      CHA_RXD         <= rxd_remote;
      CHB_RXD         <= txd_a;
    end
  end
endmodule : ccb_top

/* hw/ccb_pkg.sv */
/*
  Constants and timing figures for the communications card clock, baud and decode glue.
  Assumes one system clock SYS_CLK at 40 MHz and a synchronous active-low reset.
*/
package ccb_pkg;
  localparam int unsigned OSC_KHZ      = 7373;
  localparam int unsigned SYS_CLK_KHZ  = 40000;
  localparam int unsigned ROM_ABIT     = 15;
  localparam int unsigned SW_SEL_ABIT  = 0;
  localparam int unsigned SW_EN_ABIT   = 5;
  localparam int unsigned MC_TX_BIT    = 6;
  localparam int unsigned MC_RX_BIT    = 7;
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned SW_W         = 8;
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned BAUD_CH      = 2;
  localparam logic        SEL_INTERNAL = 1'h1;
  localparam logic [1:0]  TMR_SRC_SYS  = 2'h0;
  localparam logic [1:0]  TMR_SRC_HALF = 2'h1;
  localparam logic [1:0]  TMR_SRC_BAUD = 2'h2;
endpackage : ccb_pkg

/* hw/ccb_div_if.sv */
/*
  Carrier for the divide chain between the top module and its divider leaf.
  Assumes both ends run on SYS_CLK.
*/
`timescale 1ns/1ps
interface ccb_div_if #(parameter int unsigned N = 2);
  logic         osc_tick;
  logic [N-1:0] zc_tick;
  logic         sys_clk_q;
  logic         half_clk_q;
  logic [N-1:0] baud_q;
  modport divider (input osc_tick, input zc_tick, output sys_clk_q, output half_clk_q,
                   output baud_q);
  modport user    (output osc_tick, output zc_tick, input sys_clk_q, input half_clk_q,
                   input baud_q);
endinterface : ccb_div_if

/* hw/ccb_div.sv */
/*
  Toggle dividers: oscillator to system clock, system clock to half rate,
  and one squaring stage per baud generator channel.
  Assumes edge ticks arrive already synchronised, one cycle each.
*/
`timescale 1ns/1ps
module ccb_div
  import ccb_pkg::*;
#(
  parameter int unsigned N = BAUD_CH
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  ccb_div_if.divider dv
);
  logic sys_prev;
  logic sys_rise;

  assign sys_rise = dv.sys_clk_q & ~sys_prev;

  // Toggling on each oscillator rising edge yields a square wave whatever its duty
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dv.sys_clk_q  <= 1'b0;
      dv.half_clk_q <= 1'b0;
      sys_prev      <= 1'b0;
    end else begin
      sys_prev <= dv.sys_clk_q;
      if (dv.osc_tick) dv.sys_clk_q <= ~dv.sys_clk_q;
      if (sys_rise) dv.half_clk_q <= ~dv.half_clk_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_baud
      always_ff @(posedge sys_clk) begin
        if (!rst_n) dv.baud_q[g] <= 1'b0;
        else if (dv.zc_tick[g]) dv.baud_q[g] <= ~dv.baud_q[g];
      end
    end
  endgenerate
endmodule : ccb_div

/* bench/ccb_top_properties.sv */
/* Port properties of ccb_top, attached by bind below.
   Assumes inputs move only just after a SYS_CLK rise. */
`timescale 1ns/1ps
module ccb_top_properties
  import ccb_pkg::*;
#(
  parameter int unsigned N = BAUD_CH
) (
  input wire logic              SYS_CLK,
  input wire logic              RSTN,
  input wire logic              OSC_IN,
  input wire logic [ADDR_W-1:0] INTERNAL_ADDR,
  input wire logic              INTERNAL_MEM_REQUEST_N,
  input wire logic              INTERNAL_RD_N,
  input wire logic              INTERNAL_WR_N,
  input wire logic              INTERNAL_IO_REQUEST_N,
  input wire logic [SW_W-1:0]   DEFAULT_SWITCH_BANK,
  input wire logic [N-1:0]      ZERO_COUNT_OUTPUT,
  input wire logic [7:0]        MODEM_CONTROL,
  input wire logic              REMOTE_RX_CLK,
  input wire logic              SERIAL_WAIT_READY_A_N,
  input wire logic              WAIT_ENABLE,
  input wire logic              INT_REQ_N,
  input wire logic              ROM_SELECT_N,
  input wire logic [NIB_W-1:0]  SWITCH_DATA_OUT,
  input wire logic              SWITCH_DATA_OE,
  input wire logic              SYSTEM_CLOCK,
  input wire logic              ARBITER_CLOCK,
  input wire logic [N-1:0]      BAUD_CLOCK,
  input wire logic              SERIAL_RX_CLOCK,
  input wire logic              CPU_WAIT_N
);
  logic [2:0] cnt;
  // Synchronisers show reset values for a few edges after release
  wire        ok = (cnt >= 3'h5);
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) cnt <= 3'h0;
    else if (cnt != 3'h7) cnt <= cnt + 3'h1;
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  a_rom_decode: assert property (
    ok |-> ROM_SELECT_N == !(!$past(INTERNAL_MEM_REQUEST_N, 3) && !$past(INTERNAL_RD_N, 3)
    && $past(INTERNAL_WR_N, 3) && $past(INTERNAL_IO_REQUEST_N, 3)
    && !$past(INTERNAL_ADDR[ROM_ABIT], 3))) else $error("rom select wrong");
  a_switch_enable: assert property (
    ok |-> SWITCH_DATA_OE == (!$past(INTERNAL_ADDR[SW_EN_ABIT], 3)
    && !$past(INTERNAL_IO_REQUEST_N, 3))) else $error("switch enable wrong");
  a_switch_nibble: assert property (
    ok && SWITCH_DATA_OE |-> SWITCH_DATA_OUT == ($past(INTERNAL_ADDR[SW_SEL_ABIT], 3) ?
    $past(DEFAULT_SWITCH_BANK[7:4], 3) : $past(DEFAULT_SWITCH_BANK[3:0], 3)))
    else $error("switch nibble wrong");
  a_arbiter_clock: assert property (
    ARBITER_CLOCK == SYSTEM_CLOCK) else $error("arbiter clock differs");
  a_sys_halving: assert property (
    ok && $rose(OSC_IN) |-> ##[3:5] $changed(SYSTEM_CLOCK)) else $error("no clock toggle");
  a_baud_square: assert property (
    ok && $rose(ZERO_COUNT_OUTPUT[0]) |-> ##[3:5] $changed(BAUD_CLOCK[0]))
    else $error("no baud toggle");
  a_rx_external: assert property (
    ok && !$past(MODEM_CONTROL[MC_RX_BIT], 3) |-> SERIAL_RX_CLOCK == $past(REMOTE_RX_CLK, 3))
    else $error("rx clock not remote");
  a_wait_gate: assert property (
    ok |-> CPU_WAIT_N == !($past(WAIT_ENABLE, 3) && !$past(SERIAL_WAIT_READY_A_N, 3)
    && $past(INT_REQ_N, 3))) else $error("wait gating wrong");
  c_rom_read: cover property (ok && !ROM_SELECT_N);
  c_upper_nibble: cover property (ok && SWITCH_DATA_OE && $past(INTERNAL_ADDR[SW_SEL_ABIT], 3));
  c_rx_internal: cover property (ok && MODEM_CONTROL[MC_RX_BIT]);
endmodule : ccb_top_properties

bind ccb_top ccb_top_properties #(.N(N)) u_ccb_top_properties (.*);

/* bench/ccb_remote.sv */
/* Remote modem model: receive and transmit clocks and line data.
   Assumes the bench raises frame only while a transfer is wanted. */
`timescale 1ns/1ps
module ccb_remote (
  input  wire logic clk,
  input  wire logic frame,
  output logic      rx_clk,
  output logic      tx_clk,
  output logic      rxd
);
  logic [2:0] ph = 3'h0;
  initial begin
    rx_clk = 1'h0;
    tx_clk = 1'h0;
    rxd = 1'h1;
  end
  always @(posedge clk) begin
    if (frame) begin
      ph <= ph + 3'h1;
      rx_clk <= rx_clk ^ ph[0];
      tx_clk <= tx_clk ^ (ph == 3'h7);
      rxd <= ph[1];
    end else begin
      // Clocks stand still between frames; a failsafe receiver reads mark
      rxd <= 1'h1;
    end
  end
endmodule : ccb_remote

/* bench/comm_card_clock_baud_decode_bench.sv */
/* Self-checking bench for ccb_top with the remote clock model.
   Assumes one 40 MHz clock; oscillator is slowed to six cycles a period. */
`timescale 1ns/1ps
module comm_card_clock_baud_decode_bench
  import ccb_pkg::*;
;
  logic sys_clk = 1'h0, rstn = 1'h0, osc = 1'h0, mreq_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1;
  logic io_n = 1'h1, wait_a_n = 1'h1, wait_en = 1'h0, irq_n = 1'h1, txd = 1'h1, frame = 1'h0;
  logic [15:0] addr = 16'h0;
  logic [7:0] sw = 8'h0, mc = 8'h0;
  logic [1:0] zc = 2'h0, t23 = 2'h0, t23c, baud;
  logic rom_n, oe, sysc, arb, t01, rxc, txc, wait_n, r_txd, a_rxd, b_rxd, r_rxc, r_txc, r_rxd;
  logic [3:0] swd;
  logic [5:0] prev = 6'h0;
  wire  [5:0] mon = {sysc, t01, baud, t23c};
  int err_count = 0, samples_checked = 0, nzc = 0, tg[6], base[6];
  ccb_top u_ccb_top (
    .SYS_CLK(sys_clk), .RSTN(rstn), .OSC_IN(osc), .INTERNAL_ADDR(addr),
    .INTERNAL_MEM_REQUEST_N(mreq_n), .INTERNAL_RD_N(rd_n), .INTERNAL_WR_N(wr_n),
    .INTERNAL_IO_REQUEST_N(io_n), .DEFAULT_SWITCH_BANK(sw), .ZERO_COUNT_OUTPUT(zc),
    .TIMER23_SRC(t23), .MODEM_CONTROL(mc), .REMOTE_RX_CLK(r_rxc), .REMOTE_TX_CLK(r_txc),
    .SERIAL_WAIT_READY_A_N(wait_a_n), .WAIT_ENABLE(wait_en), .INT_REQ_N(irq_n),
    .CHA_TXD(txd), .REMOTE_RXD(r_rxd), .ROM_SELECT_N(rom_n), .SWITCH_DATA_OUT(swd),
    .SWITCH_DATA_OE(oe), .SYSTEM_CLOCK(sysc), .ARBITER_CLOCK(arb), .TIMER_EXT_CLK01(t01),
    .TIMER_EXT_CLK23(t23c), .BAUD_CLOCK(baud), .SERIAL_RX_CLOCK(rxc), .SERIAL_TX_CLOCK(txc),
    .CPU_WAIT_N(wait_n), .REMOTE_TXD(r_txd), .CHA_RXD(a_rxd), .CHB_RXD(b_rxd));
  ccb_remote u_ccb_remote (.clk(sys_clk), .frame(frame), .rx_clk(r_rxc), .tx_clk(r_txc),
    .rxd(r_rxd));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Toggle counts of the system, timer and baud clocks, compared as deltas
  always @(posedge sys_clk) begin
    prev <= mon;
    for (int i = 0; i < 6; i++) if (mon[i] !== prev[i]) tg[i]++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulses(input int n);
    repeat (n) begin
      osc <= 1'h1;
      zc <= 2'h3;
      nzc++;
      cyc(3);
      osc <= 1'h0;
      zc <= 2'h0;
      cyc(3);
    end
  endtask : pulses
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  initial begin
    cyc(4000);
    err_count++;
    final_report;
  end
  initial begin
    void'($urandom(75));
    cyc(8);
    rstn <= 1'h1;
    cyc(6);
    repeat (40) begin
      @(posedge sys_clk);
      {addr, sw} <= 24'($urandom);
      {mreq_n, rd_n, wr_n, io_n, wait_a_n, wait_en, irq_n, txd} <= 8'($urandom);
      cyc(4);
      #1;
      chk(rom_n, !(!mreq_n && !rd_n && wr_n && io_n && !addr[ROM_ABIT]));
      chk(arb, sysc);
      chk(oe, !addr[SW_EN_ABIT] && !io_n);
      if (oe === 1'h1) chk(swd, addr[SW_SEL_ABIT] ? sw[7:4] : sw[3:0]);
      chk(wait_n, !(wait_en && !wait_a_n && irq_n));
      chk({a_rxd, r_txd, b_rxd}, {r_rxd, txd, txd});
    end
    $display("decode done");
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      t23 <= s[1:0];
      cyc(4);
      #1;
      base = tg;
      @(posedge sys_clk);
      pulses(8);
      cyc(10);
      #1;
      for (int i = 0; i < 6; i++)
        chk(8'(tg[i] - base[i]), (i == 4 || (i < 2 && s == 1)) ? 8'h04 : 8'h08);
      $display("timer source %0d done", s);
    end
    // An odd pulse count leaves the internal baud clocks high; idle remote ones hold the level their last frame left
    pulses(1);
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      mc <= {m[1:0], 6'h0};
      frame <= 1'h1;
      cyc(17 + m);
      frame <= 1'h0;
      cyc(6);
      #1;
      chk(rxc, mc[MC_RX_BIT] ? 1'(nzc % 2) : r_rxc);
      chk(txc, mc[MC_TX_BIT] ? 1'(nzc % 2) : r_txc);
      $display("baud select %0d done", m);
    end
    final_report;
  end
endmodule : comm_card_clock_baud_decode_bench
